// [inc/tx_ctrl_pkg.sv]
// Purpose: Shared constants and carriers for the transmit control/status register
// Assumes: 25 MHz aclk, 32-bit AXI4-Lite register bus
// Notes:   Register index 3 maps to byte address 12
package tx_ctrl_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEFER_LIMIT_NS = 3_200_000;
  localparam int DEFER_LIMIT_CYC = DEFER_LIMIT_NS / CLK_PERIOD_NS;
  localparam int SLOT_TIME_NS = 51_200;
  localparam int SLOT_TIME_CYC = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int DEFER_CNT_W = 17;
  localparam int SLOT_CNT_W = 11;
  localparam logic [4:0] COLLISION_LIMIT = 5'h10;
  // Register map
  localparam logic [3:0] TX_CONTROL_INDEX = 4'h3;
  localparam logic [7:0] TX_CONTROL_ADDR = 8'h0C;
  localparam logic [7:0] TX_ENGINE_ADDR = 8'h10;
  localparam logic [15:0] TX_CONTROL_RESET = 16'h0102;
  // Mode bit positions in the control register
  localparam int MODE_LSB = 12;
  localparam int B_IRQ_REQ = 15;
  localparam int B_ORIGIN = 14;
  localparam int B_FCS_SUP = 13;
  localparam int B_DEF_DIS = 12;
  // Status bit positions
  localparam int B_DEF_EXCEEDED = 10;
  localparam int B_DEFERRED = 9;
  localparam int B_NO_CARRIER = 8;
  localparam int B_CARRIER_DROP = 7;
  localparam int B_COLL_LIMIT = 6;
  localparam int B_LATE_COLL = 5;
  localparam int B_MON_BAD = 3;
  localparam int B_FIFO_STARVED = 2;
  localparam int B_LEN_MISMATCH = 1;
  localparam int B_SENT_OK = 0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Events from the transmit engine, all same-clock
  typedef struct packed {
    logic cfg_fetched;
    logic [15:0] cfg_word;
    logic tx_begin;
    logic preamble_start;
    logic sfd_done;
    logic deferring;
    logic fifo_starved;
    logic frame_end;
    logic frame_good;
    logic len_mismatch;
    logic monitored_bad;
  } tx_event_s;

  // Descriptor status write-back
  typedef struct packed {
    logic valid;
    logic [4:0] collisions;
    logic [15:0] status;
  } wb_req_s;
endpackage

// [rtl/tx_control_status_register.sv]
// Purpose: Transmit control and status register with its frame-level status logic
// Assumes: Engine events on aclk; carrier and collision come from pins
// Notes:   Register index 3 sits at byte address 0x0C
`timescale 1ns/10ps
module tx_control_status_register #(
  parameter int DEFER_CYCLES = tx_ctrl_pkg::DEFER_LIMIT_CYC,
  parameter int SLOT_CYCLES = tx_ctrl_pkg::SLOT_TIME_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Transmit engine
  input wire tx_ctrl_pkg::tx_event_s tx_event,
  // Medium pins
  input wire logic carrier_sense_pin,
  input wire logic collision_pin,
  // Engine controls
  output logic append_fcs,
  output logic tx_abort,
  output logic collision_backoff,
  output logic programmed_tx_irq_flag,
  // Descriptor write-back
  output tx_ctrl_pkg::wb_req_s wb_req,
  input wire logic wb_ready
);
  import tx_ctrl_pkg::*;

  if (DEFER_CYCLES < 1 || DEFER_CYCLES >= (1 << DEFER_CNT_W)) begin : g_chk_defer
    $error("DEFER_CYCLES out of range");
  end
  if (SLOT_CYCLES < 1 || SLOT_CYCLES >= (1 << SLOT_CNT_W)) begin : g_chk_slot
    $error("SLOT_CYCLES out of range");
  end

  typedef struct packed {
    logic [15:0] ctrl;
    logic [4:0] coll;
    logic [15:0] cfg;
    logic armed;
    logic active;
    logic on_wire;
    logic slot_run;
    logic slot_over;
    logic [SLOT_CNT_W-1:0] slot_cnt;
    logic [DEFER_CNT_W-1:0] defer_cnt;
    logic [1:0] crs_s;
    logic [1:0] col_s;
    logic col_d;
    logic wb_pend;
    logic irq;
    logic abort;
    logic backoff;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic wr_go;
  logic rd_go;
  logic crs;
  logic col_rise;
  logic end_now;

  // Readable image of a register address, zero data for unmapped
  function automatic logic [31:0] read_word(input logic [7:0] addr, input state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (addr)
      TX_CONTROL_ADDR: w = {16'h0000, s.ctrl};
      TX_ENGINE_ADDR: w = {24'h00_0000, s.active, s.wb_pend, s.on_wire, s.coll};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return (addr == TX_CONTROL_ADDR) || (addr == TX_ENGINE_ADDR);
  endfunction

  // A write is taken only with both channels present; a read needs arvalid and no read response pending
  assign awready = awvalid && wvalid && !st_r.bvalid;
  assign wready = awready;
  assign wr_go = awready;
  assign arready = arvalid && !st_r.rvalid;
  assign rd_go = arready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign rvalid = st_r.rvalid;
  assign rresp = st_r.rresp;
  assign rdata = st_r.rdata;

  assign crs = st_r.crs_s[1];
  assign col_rise = st_r.col_s[1] && !st_r.col_d;
  assign append_fcs = !st_r.ctrl[B_FCS_SUP];
  assign tx_abort = st_r.abort;
  assign collision_backoff = st_r.backoff;
  assign programmed_tx_irq_flag = st_r.irq;
  assign wb_req = {st_r.wb_pend, st_r.coll, st_r.ctrl};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    end_now = 1'b0;
    st_nxt.irq = 1'b0;
    st_nxt.abort = 1'b0;
    st_nxt.backoff = 1'b0;
    // Pin synchronisers
    st_nxt.crs_s = {st_r.crs_s[0], carrier_sense_pin};
    st_nxt.col_s = {st_r.col_s[0], collision_pin};
    st_nxt.col_d = st_r.col_s[1];

    // Register bus
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (awaddr == TX_CONTROL_ADDR && wstrb[1]) begin
        st_nxt.ctrl[15:MODE_LSB] = wdata[15:MODE_LSB];
      end
    end
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      st_nxt.rdata = read_word(araddr, st_r);
    end

    // Descriptor fetch and programmed interrupt
    if (tx_event.cfg_fetched) begin
      st_nxt.cfg = tx_event.cfg_word;
      if (tx_event.cfg_word[B_IRQ_REQ] && st_r.armed) begin
        st_nxt.irq = 1'b1;
        st_nxt.armed = 1'b0;
      end
    end

    // Write-back done clears the per-frame history bits
    if (st_r.wb_pend && wb_ready) begin
      st_nxt.wb_pend = 1'b0;
      st_nxt.ctrl[B_DEFERRED] = 1'b0;
      st_nxt.ctrl[B_LATE_COLL] = 1'b0;
    end

    // Start of a transmission
    if (tx_event.tx_begin) begin
      st_nxt.ctrl[15:MODE_LSB] = st_r.cfg[15:MODE_LSB];
      if (!st_r.cfg[B_IRQ_REQ]) begin
        st_nxt.armed = 1'b1;
      end
      st_nxt.ctrl[B_DEF_EXCEEDED] = 1'b0;
      st_nxt.ctrl[B_CARRIER_DROP] = 1'b0;
      st_nxt.ctrl[B_COLL_LIMIT] = 1'b0;
      st_nxt.ctrl[B_LEN_MISMATCH] = 1'b0;
      st_nxt.ctrl[B_NO_CARRIER] = 1'b1;
      st_nxt.ctrl[B_SENT_OK] = 1'b0;
      st_nxt.ctrl[B_MON_BAD] = 1'b0;
      st_nxt.ctrl[B_FIFO_STARVED] = 1'b0;
      st_nxt.coll = 5'h00;
      st_nxt.active = 1'b1;
      st_nxt.on_wire = 1'b0;
      st_nxt.slot_run = 1'b0;
      st_nxt.slot_over = 1'b0;
      st_nxt.defer_cnt = '0;
    end

    if (st_r.active) begin
      // Deferral and its limit timer
      if (tx_event.deferring && !st_r.on_wire) begin
        if (st_r.coll == 5'h00) begin
          st_nxt.ctrl[B_DEFERRED] = 1'b1;
        end
        if (!st_r.ctrl[B_DEF_DIS]) begin
          st_nxt.defer_cnt = st_r.defer_cnt + 1'b1;
          if (st_r.defer_cnt == DEFER_CNT_W'(DEFER_CYCLES - 1)) begin
            st_nxt.ctrl[B_DEF_EXCEEDED] = 1'b1;
            end_now = 1'b1;
          end
        end
      end else begin
        st_nxt.defer_cnt = '0;
      end

      // Preamble and SFD mark the timer origin
      if (tx_event.preamble_start) begin
        st_nxt.ctrl[B_NO_CARRIER] = 1'b1;
        st_nxt.defer_cnt = '0;
        if (st_r.ctrl[B_ORIGIN]) begin
          st_nxt.slot_run = 1'b1;
          st_nxt.slot_over = 1'b0;
          st_nxt.slot_cnt = '0;
        end
      end
      if (tx_event.sfd_done) begin
        st_nxt.on_wire = 1'b1;
        if (!st_r.ctrl[B_ORIGIN]) begin
          st_nxt.slot_run = 1'b1;
          st_nxt.slot_over = 1'b0;
          st_nxt.slot_cnt = '0;
        end
      end
      if (st_r.slot_run) begin
        st_nxt.slot_cnt = st_r.slot_cnt + 1'b1;
        if (st_r.slot_cnt == SLOT_CNT_W'(SLOT_CYCLES - 1)) begin
          st_nxt.slot_run = 1'b0;
          st_nxt.slot_over = 1'b1;
        end
      end

      // Carrier watch from SFD to last byte, never aborts
      if (st_r.on_wire) begin
        if (crs) begin
          st_nxt.ctrl[B_NO_CARRIER] = 1'b0;
        end else begin
          st_nxt.ctrl[B_CARRIER_DROP] = 1'b1;
        end
      end

      // Collisions
      if (col_rise) begin
        st_nxt.coll = st_r.coll + 5'h01;
        st_nxt.ctrl[B_DEFERRED] = 1'b0;
        st_nxt.on_wire = 1'b0;
        st_nxt.slot_run = 1'b0;
        st_nxt.slot_over = 1'b0;
        if (st_r.slot_over) begin
          st_nxt.ctrl[B_LATE_COLL] = 1'b1;
        end
        if (st_r.coll + 5'h01 == COLLISION_LIMIT) begin
          st_nxt.ctrl[B_COLL_LIMIT] = 1'b1;
          end_now = 1'b1;
        end else begin
          st_nxt.backoff = 1'b1;
        end
      end

      // FIFO drained before the bus was won
      if (tx_event.fifo_starved) begin
        st_nxt.ctrl[B_FIFO_STARVED] = 1'b1;
        end_now = 1'b1;
      end

      // Normal end of frame
      if (tx_event.frame_end) begin
        st_nxt.ctrl[B_SENT_OK] = tx_event.frame_good;
        st_nxt.ctrl[B_LEN_MISMATCH] = tx_event.len_mismatch;
        st_nxt.ctrl[B_MON_BAD] = tx_event.monitored_bad && !st_r.ctrl[B_FCS_SUP];
      end

      if (end_now || tx_event.frame_end) begin
        st_nxt.abort = end_now;
        st_nxt.active = 1'b0;
        st_nxt.on_wire = 1'b0;
        st_nxt.slot_run = 1'b0;
        st_nxt.wb_pend = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Only the hardware reset touches the register; no soft reset input exists
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.ctrl <= TX_CONTROL_RESET;
      st_r.armed <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// [dv/tx_control_status_register_properties.sv]
// Purpose: Port checks for the transmit control register
// Assumes: One aclk domain, synchronous active-low reset
// Notes: Bound from the bench top
`timescale 1ns/10ps
module tx_ctrl_props
  import tx_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic bvalid,
  // Engine side
  input wire tx_ctrl_pkg::tx_event_s tx_event,
  input wire logic append_fcs,
  input wire logic tx_abort,
  input wire logic programmed_tx_irq_flag,
  input wire tx_ctrl_pkg::wb_req_s wb_req,
  input wire logic wb_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic req_seen_r;
  logic rearmed_r;
  // Own view of when a programmed interrupt may fire again
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_seen_r <= 1'b0;
      rearmed_r <= 1'b1;
    end else begin
      if (tx_event.cfg_fetched) begin
        req_seen_r <= tx_event.cfg_word[B_IRQ_REQ];
      end
      if (programmed_tx_irq_flag) begin
        rearmed_r <= 1'b0;
      end else if (tx_event.tx_begin && !req_seen_r) begin
        rearmed_r <= 1'b1;
      end
    end
  end
  sequence wb_taken;
    wb_req.valid && wb_ready;
  endsequence
  AST_MODE_FCS: assert property (tx_event.tx_begin |=> append_fcs != $past(tx_event.cfg_word[13]))
    else $error("fcs mode not loaded");
  AST_IRQ_CAUSE: assert property (programmed_tx_irq_flag |-> $past(tx_event.cfg_fetched && tx_event.cfg_word[15]))
    else $error("irq without request");
  AST_IRQ_ONCE: assert property (programmed_tx_irq_flag |=> !programmed_tx_irq_flag)
    else $error("irq repeated");
  AST_IRQ_REARM: assert property (programmed_tx_irq_flag |-> $past(rearmed_r))
    else $error("irq without re-arm");
  AST_WB_HOLD: assert property (wb_req.valid && !wb_ready |=> wb_req.valid && $stable(wb_req.collisions))
    else $error("write-back dropped");
  AST_WB_RELEASE: assert property (wb_taken |=> !wb_req.valid)
    else $error("write-back not released");
  AST_ZERO_BITS: assert property (wb_req.valid |-> !wb_req.status[11] && !wb_req.status[4])
    else $error("fixed bits not zero");
  AST_ABORT_WB: assert property (tx_abort |-> wb_req.valid)
    else $error("abort without write-back");
  AST_PMB_LOW: assert property (wb_req.valid && !append_fcs |-> !wb_req.status[B_MON_BAD])
    else $error("monitor bit with fcs off");
  AST_COLL_LIMIT: assert property (wb_req.valid && wb_req.collisions == COLLISION_LIMIT |-> wb_req.status[6])
    else $error("collision limit bit missing");
  AST_WRITE_ANSWER: assert property (awvalid && awready && wvalid |=> bvalid)
    else $error("no write response");
endmodule

// [dv/tx_medium_model.sv]
// Purpose: Medium side model driving carrier and collision pins
// Assumes: Pins are asynchronous to aclk
// Notes: Pulses are long enough for a two-stage synchroniser
`timescale 1ns/10ps
module tx_medium_model (
  // Clock
  input wire logic aclk,
  // Medium pins
  output logic carrier_sense_pin,
  output logic collision_pin
);
  initial begin
    carrier_sense_pin = 1'b0;
    collision_pin = 1'b0;
  end
  task automatic carrier(input logic on);
    carrier_sense_pin <= on;
  endtask
  task automatic collide(input int n);
    repeat (n) begin
      @(posedge aclk);
      collision_pin <= 1'b1;
      repeat (2) @(posedge aclk);
      collision_pin <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask
endmodule

// [dv/tx_control_status_register_tb_top.sv]
// Purpose: Self-checking bench for the transmit control register
// Assumes: Short deferral and slot counts
// Notes: Medium pins come from the partner model
`timescale 1ns/10ps
module tx_control_status_register_tb_top;
  import tx_ctrl_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, wb_ready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, append_fcs, tx_abort, collision_backoff;
  logic programmed_tx_irq_flag, carrier_sense_pin, collision_pin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] st;
  logic [4:0] co;
  tx_event_s tx_event;
  wb_req_s wb_req;
  int fail_count = 0, check_count = 0, n_abort = 0, n_back = 0, n_irq = 0, a0, b0, i0;
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    n_abort += int'(tx_abort);
    n_back += int'(collision_backoff);
    n_irq += int'(programmed_tx_irq_flag);
  end
  tx_control_status_register #(.DEFER_CYCLES(20), .SLOT_CYCLES(8)) i_dut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .tx_event, .carrier_sense_pin, .collision_pin, .append_fcs, .tx_abort,
    .collision_backoff, .programmed_tx_irq_flag, .wb_req, .wb_ready);
  tx_medium_model i_medium (.aclk, .carrier_sense_pin, .collision_pin);
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (!awready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(RESP_OKAY));
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk("rdata", rdata, e);
    chk("rresp", 32'(rresp), 32'(er));
  endtask
  // One frame: fetch, start, optional deferral, collisions, end
  task automatic frame(input logic [15:0] cfg, input int dly, input int nc);
    a0 = n_abort;
    b0 = n_back;
    i0 = n_irq;
    i_medium.carrier(1'b1);
    tx_event.cfg_word <= cfg;
    tx_event.cfg_fetched <= 1'b1;
    @(posedge aclk);
    tx_event.cfg_fetched <= 1'b0;
    tx_event.tx_begin <= 1'b1;
    @(posedge aclk);
    tx_event.tx_begin <= 1'b0;
    if (dly > 0) begin
      tx_event.deferring <= 1'b1;
      repeat (dly) @(posedge aclk);
      tx_event.deferring <= 1'b0;
    end
    if (!wb_req.valid) begin
      tx_event.preamble_start <= 1'b1;
      @(posedge aclk);
      tx_event.preamble_start <= 1'b0;
      tx_event.sfd_done <= 1'b1;
      @(posedge aclk);
      tx_event.sfd_done <= 1'b0;
      // Four cycles: with slot length 8 only a preamble origin makes the first hit late
      if (nc > 0) begin
        repeat (4) @(posedge aclk);
      end
      i_medium.collide(nc);
      repeat (4) @(posedge aclk);
      tx_event.frame_end <= nc < 16;
      @(posedge aclk);
      tx_event.frame_end <= 1'b0;
    end
    while (!wb_req.valid) @(posedge aclk);
    st = wb_req.status;
    co = wb_req.collisions;
    wb_ready <= 1'b1;
    i_medium.carrier(1'b0);
    @(posedge aclk);
    wb_ready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tx_event = '0;
    tx_event.frame_good = 1'b1;
    tx_event.monitored_bad = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(TX_CONTROL_ADDR, 32'h0000_0102, RESP_OKAY);
    wr(TX_CONTROL_ADDR, 32'hffff_ffff);
    rchk(TX_CONTROL_ADDR, 32'h0000_f102, RESP_OKAY);
    wr(TX_CONTROL_ADDR, 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000, RESP_SLVERR);
    frame(16'h2000, 0, 0);
    chk("fcs off", 32'(st), 32'h0000_2001);
    frame(16'h8000, 0, 0);
    chk("irq", 32'(n_irq - i0), 32'h0000_0001);
    chk("good", 32'(st), 32'h0000_8009);
    frame(16'h8000, 0, 0);
    chk("no rearm", 32'(n_irq - i0), 32'h0000_0000);
    frame(16'h4000, 0, 16);
    chk("coll st", 32'(st), 32'h0000_4060);
    chk("coll n", 32'(co), 32'h0000_0010);
    chk("backoff", 32'(n_back - b0), 32'h0000_000f);
    chk("abort", 32'(n_abort - a0), 32'h0000_0001);
    rchk(TX_CONTROL_ADDR, 32'h0000_4040, RESP_OKAY);
    frame(16'h0000, 0, 1);
    chk("early coll", 32'(st), 32'h0000_0009);
    chk("early n", 32'(co), 32'h0000_0001);
    chk("early backoff", 32'(n_back - b0), 32'h0000_0001);
    frame(16'h0000, 25, 0);
    chk("defer", 32'({st[10], 31'(n_abort - a0)}), 32'h8000_0001);
    frame(16'h1000, 25, 0);
    chk("no limit", 32'(st), 32'h0000_1209);
    summarize();
  end
  initial begin
    repeat (3000) @(posedge aclk);
    fail_count++;
    summarize();
  end
endmodule
bind tx_control_status_register tx_ctrl_props i_props (.aclk, .aresetn, .awvalid, .awready, .wvalid, .bvalid,
  .tx_event, .append_fcs, .tx_abort, .programmed_tx_irq_flag, .wb_req, .wb_ready);
